// *** hw/hps_pkg.sv ***
// constants and types shared by the host pixel path and panel scan
package hps_pkg;

  // core clock and derived panel pixel clock
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned PIX_CLK_HZ = 9_000_000;
  localparam int unsigned PIX_DIV = CLK_HZ / PIX_CLK_HZ;
  localparam logic [4:0] PIX_DIV_LAST = 5'(PIX_DIV - 1);
  localparam logic [4:0] PIX_DIV_HALF = 5'(PIX_DIV / 2);

  // line timing in panel pixel clocks; back porch counts from sync start
  localparam logic [9:0] H_ACTIVE = 10'h1e0;
  localparam logic [9:0] H_SYNC = 10'h004;
  localparam logic [9:0] H_BP = 10'h02b;
  localparam logic [9:0] H_FP = 10'h008;
  localparam logic [9:0] H_LAST = 10'(H_BP + H_ACTIVE + H_FP - 10'h001);

  // frame timing in lines
  localparam logic [8:0] V_ACTIVE = 9'h110;
  localparam logic [8:0] V_SYNC = 9'h004;
  localparam logic [8:0] V_BP = 9'h00c;
  localparam logic [8:0] V_FP = 9'h008;
  localparam logic [8:0] V_LAST = 9'(V_BP + V_ACTIVE + V_FP - 9'h001);

  // host commands handled here
  localparam logic [7:0] CMD_SET_COL = 8'h2a;
  localparam logic [7:0] CMD_SET_PAGE = 8'h2b;
  localparam logic [7:0] CMD_WR_START = 8'h2c;
  localparam logic [7:0] CMD_WR_CONT = 8'h3c;

  // window reset values: full panel
  localparam logic [8:0] COL_START_RST = 9'h000;
  localparam logic [8:0] COL_END_RST = 9'h1df;
  localparam logic [8:0] PAGE_START_RST = 9'h000;
  localparam logic [8:0] PAGE_END_RST = 9'h10f;
  localparam logic [1:0] PARAM_LAST = 2'h3;

  // pixel word carried through the buffer: row, column, rgb888
  localparam int unsigned PIX_W = 42;

  typedef enum logic [1:0] {
    HM_IDLE = 2'b00,
    HM_COL = 2'b01,
    HM_PAGE = 2'b10,
    HM_MEM = 2'b11
  } hps_mode_t;

endpackage

// *** hw/hps_buf2.sv ***
// two-entry flop buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module hps_buf2 #(
  parameter int unsigned W = 42
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);

  logic [W-1:0] mem_reg [2];
  logic wr_idx_reg;
  logic rd_idx_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign o_ready = (count_reg != 2'h2);
  assign o_valid = (count_reg != 2'h0);
  assign o_data = mem_reg[rd_idx_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_idx_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_idx_reg <= 1'b0;
      rd_idx_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_idx_reg <= ~wr_idx_reg;
      end
      if (pop) begin
        rd_idx_reg <= ~rd_idx_reg;
      end
      case ({push, pop})
        2'b10: count_reg <= count_reg + 2'h1;
        2'b01: count_reg <= count_reg - 2'h1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** hw/hps_top.sv ***
// host bus pixel packing, write pointer and panel scan timing
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// R1 - 16-bit 5-6-5: one word per pixel, red 15:11, green 10:5, blue 4:0
// R2 - 8-bit: three bytes on lines 7:0, red then green then blue
// R3 - host uses only 8-bit or 16-bit bus widths
// R4 - 480 active clocks per line, period 531, sync 4, porches 43 and 8
// R5 - 272 active lines per frame, period 292, sync 4, porches 12 and 8
// R6 - core clock from pll when enabled, else from the external clock; the pll is picked here only when enabled and locked
// R7 - command 0x2c starts pixel writes at the window start position
// R8 - command 0x3c resumes pixel writes after the last written location
// R9 - select low for command bytes, high for parameters and pixels
module hps_top (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // host 8080 bus pins
  input wire logic I_CS_N,
  input wire logic I_WR_N,
  input wire logic I_RD_N,
  input wire logic I_CMD_DATA_SELECT,
  input wire logic [15:0] I_HOST_DATA_LINES,
  output logic [15:0] O_HOST_DATA_LINES,
  output logic O_HOST_DATA_OE,
  output logic O_HOST_BUSY,
  // bus configuration straps
  input wire logic I_BUS_16BIT,
  input wire logic I_PACK_24BIT,
  // core clock source
  input wire logic I_PLL_ENABLE,
  input wire logic I_PLL_LOCKED,
  output logic O_CORE_CLK_SEL_PLL,
  // pixel stream toward frame memory
  output logic O_PIX_VALID,
  input wire logic I_PIX_READY,
  output logic [23:0] O_PIX_RGB,
  output logic [8:0] O_PIX_COL,
  output logic [8:0] O_PIX_ROW,
  // panel scan
  output logic O_PANEL_PIXEL_CLOCK,
  output logic O_LINE_SYNC_N,
  output logic O_FRAME_SYNC_N,
  output logic O_DATA_ENABLE
);

  function automatic logic [7:0] widen(input logic [7:0] v, input logic six);
    widen = six ? {v[5:0], v[5:4]} : {v[4:0], v[4:2]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [21:0] pin_s1_reg;
  logic [21:0] pin_s2_reg;
  logic wr_n_d_reg;
  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  logic sel_s;
  logic bus16_s;
  logic pack24_s;
  logic pll_en_s;
  logic pll_lock_s;
  logic [15:0] data_s;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      // idle levels: strobes and select high, pll off, so no false pll pick
      pin_s1_reg <= 22'h03c000;
      pin_s2_reg <= 22'h03c000;
      wr_n_d_reg <= 1'b1;
    end else begin
      pin_s1_reg <= {I_PLL_LOCKED, I_PLL_ENABLE, I_PACK_24BIT, I_BUS_16BIT, I_CS_N,
                     I_WR_N, I_RD_N, I_CMD_DATA_SELECT, I_HOST_DATA_LINES[13:0]};
      pin_s2_reg <= pin_s1_reg;
      wr_n_d_reg <= wr_n_s;
    end
  end

  // upper data lines travel in their own pair to keep the vector readable
  logic [1:0] hi_s1_reg;
  logic [1:0] hi_s2_reg;
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      hi_s1_reg <= 2'h0;
      hi_s2_reg <= 2'h0;
    end else begin
      hi_s1_reg <= I_HOST_DATA_LINES[15:14];
      hi_s2_reg <= hi_s1_reg;
    end
  end

  assign pll_lock_s = pin_s2_reg[21];
  assign pll_en_s = pin_s2_reg[20];
  assign pack24_s = pin_s2_reg[19];
  assign bus16_s = pin_s2_reg[18];
  assign cs_n_s = pin_s2_reg[17];
  assign wr_n_s = pin_s2_reg[16];
  assign rd_n_s = pin_s2_reg[15];
  assign sel_s = pin_s2_reg[14];
  assign data_s = {hi_s2_reg, pin_s2_reg[13:0]};

  //////////////////////////////////////////////////////////////////////////////
  // write strobe: data sampled while low, acted on at the rising edge;
  // the data hold after the strobe is far below one clock, so the edge
  // itself cannot be used to sample
  logic [15:0] wdata_reg;
  logic wsel_reg;
  logic wr_strobe;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      wdata_reg <= 16'h0000;
      wsel_reg <= 1'b0;
    end else if (!wr_n_s && !cs_n_s) begin
      wdata_reg <= data_s;
      wsel_reg <= sel_s;
    end
  end

  assign wr_strobe = wr_n_s && !wr_n_d_reg && !cs_n_s;

  //////////////////////////////////////////////////////////////////////////////
  // command decode and window parameters
  hps_pkg::hps_mode_t mode_reg;
  logic [1:0] param_cnt_reg;
  logic [8:0] col_start_reg;
  logic [8:0] col_end_reg;
  logic [8:0] page_start_reg;
  logic [8:0] page_end_reg;
  logic cmd_wr;
  logic par_wr;

  assign cmd_wr = wr_strobe && !wsel_reg; // [R9]
  assign par_wr = wr_strobe && wsel_reg; // [R9]

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      mode_reg <= hps_pkg::HM_IDLE;
      param_cnt_reg <= 2'h0;
    end else if (cmd_wr) begin
      param_cnt_reg <= 2'h0;
      case (wdata_reg[7:0])
        hps_pkg::CMD_SET_COL: mode_reg <= hps_pkg::HM_COL;
        hps_pkg::CMD_SET_PAGE: mode_reg <= hps_pkg::HM_PAGE;
        hps_pkg::CMD_WR_START: mode_reg <= hps_pkg::HM_MEM; // [R7]
        hps_pkg::CMD_WR_CONT: mode_reg <= hps_pkg::HM_MEM; // [R8]
        default: mode_reg <= hps_pkg::HM_IDLE;
      endcase
    end else if (par_wr && (mode_reg == hps_pkg::HM_COL || mode_reg == hps_pkg::HM_PAGE)) begin
      param_cnt_reg <= param_cnt_reg + 2'h1;
      if (param_cnt_reg == hps_pkg::PARAM_LAST) begin
        mode_reg <= hps_pkg::HM_IDLE;
      end
    end
  end

  // parameter order: start high, start low, end high, end low
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      col_start_reg <= hps_pkg::COL_START_RST;
      col_end_reg <= hps_pkg::COL_END_RST;
      page_start_reg <= hps_pkg::PAGE_START_RST;
      page_end_reg <= hps_pkg::PAGE_END_RST;
    end else if (par_wr && mode_reg == hps_pkg::HM_COL) begin
      case (param_cnt_reg)
        2'h0: col_start_reg[8] <= wdata_reg[0];
        2'h1: col_start_reg[7:0] <= wdata_reg[7:0];
        2'h2: col_end_reg[8] <= wdata_reg[0];
        default: col_end_reg[7:0] <= wdata_reg[7:0];
      endcase
    end else if (par_wr && mode_reg == hps_pkg::HM_PAGE) begin
      case (param_cnt_reg)
        2'h0: page_start_reg[8] <= wdata_reg[0];
        2'h1: page_start_reg[7:0] <= wdata_reg[7:0];
        2'h2: page_end_reg[8] <= wdata_reg[0];
        default: page_end_reg[7:0] <= wdata_reg[7:0];
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pixel packing
  logic [1:0] phase_reg;
  logic [7:0] hold_a_reg;
  logic [7:0] hold_b_reg;
  logic [7:0] hold_c_reg;
  logic pix_word;
  logic pix_done;
  logic [23:0] pix_rgb;
  logic pend_valid_reg;
  logic [23:0] pend_rgb_reg;
  logic [8:0] pend_col_reg;
  logic [8:0] pend_row_reg;
  logic buf_in_ready;
  logic take;

  // words that arrive while a pixel waits for buffer room are dropped
  assign pix_word = par_wr && mode_reg == hps_pkg::HM_MEM && !pend_valid_reg;

  always_comb begin
    pix_done = 1'b0;
    pix_rgb = 24'h000000;
    if (pix_word) begin
      if (!bus16_s) begin
        pix_done = (phase_reg == 2'h2); // [R2]
        pix_rgb = {hold_a_reg, hold_b_reg, wdata_reg[7:0]}; // [R2]
      end else if (!pack24_s) begin
        pix_done = 1'b1; // [R1]
        pix_rgb = {widen({3'h0, wdata_reg[15:11]}, 1'b0),
                   widen({2'h0, wdata_reg[10:5]}, 1'b1),
                   widen({3'h0, wdata_reg[4:0]}, 1'b0)}; // [R1]
      end else begin
        // three words carry two pixels: rg, b r, g b
        pix_done = (phase_reg != 2'h0);
        pix_rgb = (phase_reg == 2'h1) ? {hold_a_reg, hold_b_reg, wdata_reg[15:8]} :
                  {hold_c_reg, wdata_reg};
      end
    end
  end

  // only the 8-bit and 16-bit widths exist; nothing else is decoded [R3]
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      phase_reg <= 2'h0;
      hold_a_reg <= 8'h00;
      hold_b_reg <= 8'h00;
      hold_c_reg <= 8'h00;
    end else if (cmd_wr) begin
      phase_reg <= 2'h0;
    end else if (pix_word) begin
      if (!bus16_s) begin
        phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1; // [R2]
        if (phase_reg == 2'h0) begin
          hold_a_reg <= wdata_reg[7:0];
        end
        if (phase_reg == 2'h1) begin
          hold_b_reg <= wdata_reg[7:0];
        end
      end else if (pack24_s) begin
        phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
        if (phase_reg == 2'h0) begin
          hold_a_reg <= wdata_reg[15:8];
          hold_b_reg <= wdata_reg[7:0];
        end
        if (phase_reg == 2'h1) begin
          hold_c_reg <= wdata_reg[7:0];
        end
      end else begin
        phase_reg <= 2'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write pointer and pending pixel
  logic [8:0] col_ptr_reg;
  logic [8:0] row_ptr_reg;

  assign take = pix_done;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      col_ptr_reg <= hps_pkg::COL_START_RST;
      row_ptr_reg <= hps_pkg::PAGE_START_RST;
    end else if (cmd_wr && wdata_reg[7:0] == hps_pkg::CMD_WR_START) begin
      col_ptr_reg <= col_start_reg; // [R7]
      row_ptr_reg <= page_start_reg; // [R7]
    end else if (take) begin
      // 0x3c leaves the pointer alone and continues from here [R8]
      if (col_ptr_reg == col_end_reg) begin
        col_ptr_reg <= col_start_reg;
        row_ptr_reg <= (row_ptr_reg == page_end_reg) ? page_start_reg : row_ptr_reg + 9'h001;
      end else begin
        col_ptr_reg <= col_ptr_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      pend_valid_reg <= 1'b0;
      pend_rgb_reg <= 24'h000000;
      pend_col_reg <= 9'h000;
      pend_row_reg <= 9'h000;
    end else if (take) begin
      pend_valid_reg <= 1'b1;
      pend_rgb_reg <= pix_rgb;
      pend_col_reg <= col_ptr_reg;
      pend_row_reg <= row_ptr_reg;
    end else if (buf_in_ready) begin
      pend_valid_reg <= 1'b0;
    end
  end

  assign O_HOST_BUSY = pend_valid_reg;

  hps_buf2 #(
    .W(hps_pkg::PIX_W)
  ) u_buf (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_valid(pend_valid_reg),
    .o_ready(buf_in_ready),
    .i_data({pend_row_reg, pend_col_reg, pend_rgb_reg}),
    .o_valid(O_PIX_VALID),
    .i_ready(I_PIX_READY),
    .o_data({O_PIX_ROW, O_PIX_COL, O_PIX_RGB})
  );

  //////////////////////////////////////////////////////////////////////////////
  // host reads return the current write column
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_HOST_DATA_OE <= 1'b0;
      O_HOST_DATA_LINES <= 16'h0000;
    end else begin
      O_HOST_DATA_OE <= !cs_n_s && !rd_n_s;
      O_HOST_DATA_LINES <= {7'h00, col_ptr_reg};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core clock source select; switch to the pll only once it is locked
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_CORE_CLK_SEL_PLL <= 1'b0;
    end else begin
      O_CORE_CLK_SEL_PLL <= pll_en_s && pll_lock_s; // [R6]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // panel scan
  logic [4:0] div_reg;
  logic tick;
  logic [9:0] h_reg;
  logic [8:0] v_reg;

  assign tick = (div_reg == hps_pkg::PIX_DIV_LAST);

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      div_reg <= 5'h00;
      O_PANEL_PIXEL_CLOCK <= 1'b0;
    end else begin
      div_reg <= tick ? 5'h00 : div_reg + 5'h01;
      O_PANEL_PIXEL_CLOCK <= (div_reg >= hps_pkg::PIX_DIV_HALF);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      h_reg <= 10'h000;
      v_reg <= 9'h000;
    end else if (tick) begin
      if (h_reg == hps_pkg::H_LAST) begin // [R4]
        h_reg <= 10'h000;
        v_reg <= (v_reg == hps_pkg::V_LAST) ? 9'h000 : v_reg + 9'h001; // [R5]
      end else begin
        h_reg <= h_reg + 10'h001;
      end
    end
  end

  // outputs change on the panel clock falling edge so the panel samples mid-cell
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_LINE_SYNC_N <= 1'b1;
      O_FRAME_SYNC_N <= 1'b1;
      O_DATA_ENABLE <= 1'b0;
    end else begin
      O_LINE_SYNC_N <= !(h_reg < hps_pkg::H_SYNC); // [R4]
      O_FRAME_SYNC_N <= !(v_reg < hps_pkg::V_SYNC); // [R5]
      O_DATA_ENABLE <= (h_reg >= hps_pkg::H_BP) && (h_reg < 10'(hps_pkg::H_BP + hps_pkg::H_ACTIVE))
                       && (v_reg >= hps_pkg::V_BP)
                       && (v_reg < 9'(hps_pkg::V_BP + hps_pkg::V_ACTIVE)); // [R4] [R5]
    end
  end

endmodule
`default_nettype wire

// *** tb/hps_top_monitor.sv ***
// assertion checker for the host pixel path and panel scan
`timescale 1ns/10ps
`default_nettype none
module hps_top_monitor (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // pll and pixel stream
  input wire logic I_PLL_ENABLE,
  input wire logic I_PLL_LOCKED,
  input wire logic O_CORE_CLK_SEL_PLL,
  input wire logic O_PIX_VALID,
  input wire logic I_PIX_READY,
  input wire logic [23:0] O_PIX_RGB,
  input wire logic [8:0] O_PIX_COL,
  input wire logic [8:0] O_PIX_ROW,
  // panel scan
  input wire logic O_PANEL_PIXEL_CLOCK,
  input wire logic O_LINE_SYNC_N,
  input wire logic O_FRAME_SYNC_N,
  input wire logic O_DATA_ENABLE
);
  int hs_lo;
  int hs_per;
  int fs_lo;
  logic hs_seen;
  // the first line after reset has no earlier fall to measure from
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      hs_lo <= 0;
      hs_per <= 0;
      fs_lo <= 0;
      hs_seen <= 1'b0;
    end else begin
      hs_lo <= O_LINE_SYNC_N ? 0 : hs_lo + 1;
      hs_per <= $fell(O_LINE_SYNC_N) ? 1 : hs_per + 1;
      fs_lo <= O_FRAME_SYNC_N ? 0 : fs_lo + 1;
      hs_seen <= hs_seen | $fell(O_LINE_SYNC_N);
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence s_pclk_high;
    ##11 $fell(O_PANEL_PIXEL_CLOCK);
  endsequence
  sequence s_pclk_low;
    ##11 $rose(O_PANEL_PIXEL_CLOCK);
  endsequence
  property p_pclk;
    $rose(O_PANEL_PIXEL_CLOCK) |-> s_pclk_high ##0 s_pclk_low;
  endproperty
  property p_hs_width;
    $rose(O_LINE_SYNC_N) |-> hs_lo == 88;
  endproperty
  property p_line_per;
    $fell(O_LINE_SYNC_N) && hs_seen |-> hs_per == 11682;
  endproperty
  property p_fs_width;
    $rose(O_FRAME_SYNC_N) |-> fs_lo == 46728;
  endproperty
  property p_de_hblank;
    !O_LINE_SYNC_N |-> !O_DATA_ENABLE;
  endproperty
  property p_de_vblank;
    !O_FRAME_SYNC_N |-> !O_DATA_ENABLE;
  endproperty
  property p_sel_on;
    (I_PLL_ENABLE && I_PLL_LOCKED) [*4] |-> O_CORE_CLK_SEL_PLL;
  endproperty
  property p_sel_off;
    !(I_PLL_ENABLE && I_PLL_LOCKED) [*4] |-> !O_CORE_CLK_SEL_PLL;
  endproperty
  property p_pix_hold;
    O_PIX_VALID && !I_PIX_READY |=> O_PIX_VALID && $stable(O_PIX_RGB)
      && $stable(O_PIX_COL) && $stable(O_PIX_ROW);
  endproperty
  a_pclk: assert property (p_pclk) else $error("pixel clock period");
  a_hs_width: assert property (p_hs_width) else $error("line sync width");
  a_line_per: assert property (p_line_per) else $error("line period");
  a_fs_width: assert property (p_fs_width) else $error("frame sync width");
  a_de_hblank: assert property (p_de_hblank) else $error("enable in line sync");
  a_de_vblank: assert property (p_de_vblank) else $error("enable in frame sync");
  a_sel_on: assert property (p_sel_on) else $error("pll clock not chosen");
  a_sel_off: assert property (p_sel_off) else $error("pll clock chosen");
  a_pix_hold: assert property (p_pix_hold) else $error("pixel changed in stall");
endmodule
bind hps_top hps_top_monitor u_mon (.I_CLK, .I_SRST, .I_PLL_ENABLE, .I_PLL_LOCKED,
  .O_CORE_CLK_SEL_PLL, .O_PIX_VALID, .I_PIX_READY, .O_PIX_RGB, .O_PIX_COL, .O_PIX_ROW,
  .O_PANEL_PIXEL_CLOCK, .O_LINE_SYNC_N, .O_FRAME_SYNC_N, .O_DATA_ENABLE);
`default_nettype wire

// *** tb/hps_host_model.sv ***
// host processor model on the 8080 style bus
`timescale 1ns/10ps
`default_nettype none
module hps_host_model (
  // host bus
  input wire logic i_clk,
  input wire logic [15:0] i_data,
  output logic o_cs_n,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic o_sel,
  output logic [15:0] o_data
);
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_sel = 1'b1;
    o_data = 16'h0000;
  end
  // only 8 or 16 bit words leave this model
  task automatic wr(input logic s, input logic [15:0] d);
    @(negedge i_clk);
    o_cs_n <= 1'b0;
    o_sel <= s;
    o_data <= d;
    o_wr_n <= 1'b0;
    repeat (4) @(negedge i_clk);
    o_wr_n <= 1'b1;
    // data held while the synchronisers still see the strobe low
    repeat (4) @(negedge i_clk);
    o_cs_n <= 1'b1;
    o_data <= ~d;
  endtask
  task automatic rd(output logic [15:0] q);
    @(negedge i_clk);
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    repeat (6) @(negedge i_clk);
    q = i_data;
    o_rd_n <= 1'b1;
    o_cs_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the host pixel path and panel scan
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, srst, rdy, b16, p24, pen, plk;
  logic cs_n, wr_n, rd_n, sel, oe, busy, psel, pv, pclk, hs_n, fs_n, de;
  logic [15:0] md, dout, bus, q;
  logic [23:0] rgb;
  logic [8:0] col, row;
  int mismatches = 0;
  int cmp_count = 0;
  int fs_lo = 0;
  assign bus = oe ? dout : md;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) if (fs_n === 1'b0) fs_lo <= fs_lo + 1;
  hps_host_model host (.i_clk(clk), .i_data(bus), .o_cs_n(cs_n), .o_wr_n(wr_n),
    .o_rd_n(rd_n), .o_sel(sel), .o_data(md));
  hps_top uut (.I_CLK(clk), .I_SRST(srst), .I_CS_N(cs_n), .I_WR_N(wr_n), .I_RD_N(rd_n),
    .I_CMD_DATA_SELECT(sel), .I_HOST_DATA_LINES(bus), .O_HOST_DATA_LINES(dout),
    .O_HOST_DATA_OE(oe), .O_HOST_BUSY(busy), .I_BUS_16BIT(b16), .I_PACK_24BIT(p24),
    .I_PLL_ENABLE(pen), .I_PLL_LOCKED(plk), .O_CORE_CLK_SEL_PLL(psel), .O_PIX_VALID(pv),
    .I_PIX_READY(rdy), .O_PIX_RGB(rgb), .O_PIX_COL(col), .O_PIX_ROW(row),
    .O_PANEL_PIXEL_CLOCK(pclk), .O_LINE_SYNC_N(hs_n), .O_FRAME_SYNC_N(fs_n),
    .O_DATA_ENABLE(de));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pix(input logic [8:0] c, input logic [8:0] r, input logic [23:0] x);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pv !== 1'b1 && n < 300);
    if (pv !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    cmp_count++;
    if ({rgb, col, row} !== {x, c, r}) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {rgb, col, row}, {x, c, r});
    end
    rdy <= 1'b1;
    @(negedge clk);
    rdy <= 1'b0;
  endtask
  task automatic wait_hs(input logic v, inout int n);
    int k;
    k = 0;
    while (hs_n !== v) begin
      @(negedge clk);
      n++;
      k++;
      if (k > 12000) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask
  function automatic logic [23:0] x565(input logic [15:0] w);
    return {w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2]};
  endfunction
  task automatic t_565();
    host.wr(1'b0, 16'h002c);
    host.wr(1'b1, 16'h8c51);
    host.wr(1'b1, 16'h7bae);
    chk_pix(9'h000, 9'h000, x565(16'h8c51));
    chk_pix(9'h001, 9'h000, x565(16'h7bae));
    $display("test 565 done");
  endtask
  task automatic t_8bit();
    b16 <= 1'b0;
    host.wr(1'b0, 16'h003c);
    host.wr(1'b1, 16'h00c3);
    host.wr(1'b1, 16'h005a);
    host.wr(1'b1, 16'h0081);
    chk_pix(9'h002, 9'h000, 24'hc35a81);
    host.rd(q);
    chk_v(q, 32'h0003);
    $display("test 8bit done");
  endtask
  task automatic t_24();
    b16 <= 1'b1;
    p24 <= 1'b1;
    host.wr(1'b0, 16'h002a);
    host.wr(1'b1, 16'h0000);
    host.wr(1'b1, 16'h0005);
    host.wr(1'b1, 16'h0000);
    host.wr(1'b1, 16'h0006);
    host.wr(1'b0, 16'h002c);
    host.wr(1'b1, 16'h1122);
    host.wr(1'b1, 16'h3344);
    host.wr(1'b1, 16'h5566);
    chk_pix(9'h005, 9'h000, 24'h112233);
    chk_pix(9'h006, 9'h000, 24'h445566);
    host.wr(1'b1, 16'h7788);
    host.wr(1'b1, 16'h99aa);
    host.wr(1'b1, 16'hbbcc);
    chk_pix(9'h005, 9'h001, 24'h778899);
    chk_pix(9'h006, 9'h001, 24'haabbcc);
    $display("test 24bit done");
  endtask
  task automatic t_stall();
    p24 <= 1'b0;
    host.wr(1'b0, 16'h002c);
    host.wr(1'b1, 16'h1234);
    host.wr(1'b1, 16'h5678);
    host.wr(1'b1, 16'h9abc);
    host.wr(1'b1, 16'hdef0);
    chk_v(busy, 32'h1);
    chk_pix(9'h005, 9'h000, x565(16'h1234));
    chk_pix(9'h006, 9'h000, x565(16'h5678));
    chk_pix(9'h005, 9'h001, x565(16'h9abc));
    chk_v({busy, pv}, 32'h0);
    host.wr(1'b1, 16'h0f0f);
    chk_pix(9'h006, 9'h001, x565(16'h0f0f));
    $display("test stall done");
  endtask
  task automatic t_pll();
    pen <= 1'b1;
    repeat (6) @(negedge clk);
    chk_v(psel, 32'h0);
    plk <= 1'b1;
    repeat (6) @(negedge clk);
    chk_v(psel, 32'h1);
    pen <= 1'b0;
    repeat (6) @(negedge clk);
    chk_v(psel, 32'h0);
    $display("test pll done");
  endtask
  task automatic t_scan();
    int n;
    n = 0;
    while (fs_n !== 1'b1 && n < 60000) begin
      @(negedge clk);
      n++;
    end
    if (fs_n !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    chk_v(fs_lo, 32'd46728);
    chk_v(de, 32'h0);
    wait_hs(1'b1, n);
    wait_hs(1'b0, n);
    n = 0;
    wait_hs(1'b1, n);
    chk_v(n, 32'd88);
    wait_hs(1'b0, n);
    chk_v(n, 32'd11682);
    $display("test scan done");
  endtask
  initial begin
    srst = 1'b1;
    rdy = 1'b0;
    b16 = 1'b1;
    p24 = 1'b0;
    pen = 1'b0;
    plk = 1'b0;
    repeat (20) @(negedge clk);
    chk_v({oe, busy, pv, psel, hs_n, fs_n}, 32'h3);
    srst <= 1'b0;
    // pll select must not flicker while the synchronisers refill
    repeat (3) begin
      @(negedge clk);
      chk_v({psel, busy, pv, oe}, 32'h0);
    end
    t_565();
    t_8bit();
    t_24();
    t_stall();
    t_pll();
    t_scan();
    report_and_stop();
  end
endmodule
`default_nettype wire
